// ### acs_i2c_slave.sv
`timescale 1ns/10ps
// Function
// RULE1 - Target only, never starts a transfer
// RULE2 - Answer only bus address 0x70
// RULE3 - Address LSB one reads, zero writes
// RULE4 - SDA fall with SCL high starts
// RULE5 - Shift eight address bits MSB first
// RULE6 - Matching address acknowledged on ninth clock
// RULE7 - Mismatch releases bus, idles until start
// RULE8 - SDA rise with SCL high stops
// RULE9 - Stray start or stop aborts immediately
// RULE10 - Master: one condition per SCL high
// RULE11 - Bad subaddress: no acknowledge, idle
// RULE12 - Subaddress advances after every data byte
// RULE13 - Acknowledge each written subaddress and byte
// RULE14 - Write past top dropped, nacked, idle
// RULE15 - Master writes subaddress, then repeated start
// RULE16 - Read bytes driven MSB first, master acks
// RULE17 - Read past top repeats top register
// RULE18 - Soft reset bit restores all defaults
// RULE19 - Lines synchronised before edge detection
module acs_i2c_slave (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Two-wire bus
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_val,
  output logic sda_en,
  // Register contents, subaddress i in bits 8i+7..8i
  output logic [63:0] cfg_regs
);

  wire [1:0] pins;
  wire [1:0] filt;
  wire [1:0] filt_prev;
  wire [7:0][7:0] regs;
  acs_pkg::acs_line_ev_type ev;
  acs_pkg::acs_state_type st_r;
  acs_pkg::acs_state_type st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [2:0] sub_r;
  logic [2:0] sub_nxt;
  logic ack_r;
  logic ack_nxt;
  logic oe_r;
  logic oe_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic wr_en;
  logic sda_val_r;

  assign pins = {sda_pin, scl_pin};

  // Three stages per line; a level is taken only once stages two and
  // three agree, which rejects a single-sample glitch on the wire
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic f_r;
      logic p_r;
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          f_r <= 1'b1;
          p_r <= 1'b1;
        end
        else if (clk_en)
        begin
          s1_r <= pins[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          f_r <= (s2_r == s3_r) ? s3_r : f_r; // [RULE19]
          p_r <= f_r;
        end
      end
      assign filt[g] = f_r;
      assign filt_prev[g] = p_r;
    end
  endgenerate

  // Bus events from filtered samples only
  assign ev.start = filt_prev[0] & filt[0] & filt_prev[1] & ~filt[1]; // [RULE4]
  assign ev.stop = filt_prev[0] & filt[0] & ~filt_prev[1] & filt[1]; // [RULE8]
  assign ev.scl_rise = ~filt_prev[0] & filt[0];
  assign ev.scl_fall = filt_prev[0] & ~filt[0];
  assign ev.sda = filt[1];

  wire byte_done = ev.scl_fall && !ack_r && cnt_r == acs_pkg::BYTE_BITS;
  wire addr_hit = sh_r[7:1] == acs_pkg::DEV_ADDR; // [RULE2]
  wire sub_ok = sh_r < acs_pkg::SUB_LIMIT; // [RULE11]
  wire at_top = sub_r == acs_pkg::TOP_SUB;
  wire [2:0] sub_inc = at_top ? sub_r : sub_r + acs_pkg::SUB_STEP;
  wire [7:0] rd_byte = regs[sub_r];
  wire srst = wr_en && sub_r == acs_pkg::OFS_POWER_RESET_CLOCK_SELECT
    && sh_r[acs_pkg::SRST_BIT];

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    sub_nxt = sub_r;
    ack_nxt = ack_r;
    oe_nxt = oe_r;
    ovf_nxt = ovf_r;
    wr_en = 1'b0;
    if (ev.stop)
    begin
      st_nxt = acs_pkg::ST_IDLE; // [RULE8] [RULE9]
      ack_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (ev.start)
    begin
      // A repeated start keeps the subaddress for the following read
      st_nxt = acs_pkg::ST_ADDR; // [RULE4] [RULE9] [RULE15]
      cnt_nxt = '0;
      ack_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (ack_r && ev.scl_fall)
    begin
      // End of the ninth clock; a read loads its byte here
      ack_nxt = 1'b0;
      cnt_nxt = '0;
      oe_nxt = 1'b0;
      if (st_r == acs_pkg::ST_RDATA)
      begin
        sh_nxt = rd_byte;
        oe_nxt = ~rd_byte[7]; // [RULE16]
      end
    end
    else
    begin
      case (st_r)
        acs_pkg::ST_ADDR, acs_pkg::ST_SUB, acs_pkg::ST_WDATA:
        begin
          if (ev.scl_rise && !ack_r)
          begin
            sh_nxt = {sh_r[6:0], ev.sda}; // [RULE5]
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            st_nxt = acs_pkg::ST_IDLE;
            if (st_r == acs_pkg::ST_ADDR && addr_hit)
            begin
              ack_nxt = 1'b1;
              oe_nxt = 1'b1; // [RULE6]
              st_nxt = sh_r[0] ? acs_pkg::ST_RDATA : acs_pkg::ST_SUB; // [RULE3]
            end
            else if (st_r == acs_pkg::ST_SUB && sub_ok)
            begin
              sub_nxt = sh_r[2:0];
              ovf_nxt = 1'b0;
              ack_nxt = 1'b1;
              oe_nxt = 1'b1; // [RULE13]
              st_nxt = acs_pkg::ST_WDATA;
            end
            else if (st_r == acs_pkg::ST_WDATA && !ovf_r)
            begin
              wr_en = 1'b1;
              ack_nxt = 1'b1;
              oe_nxt = 1'b1; // [RULE13]
              st_nxt = acs_pkg::ST_WDATA;
              sub_nxt = sub_inc; // [RULE12]
              ovf_nxt = at_top; // [RULE14]
            end
          end
        end
        acs_pkg::ST_RDATA:
        begin
          if (ev.scl_rise)
            cnt_nxt = cnt_r + 4'h1;
          else if (ev.scl_fall && cnt_r == acs_pkg::BYTE_BITS)
          begin
            oe_nxt = 1'b0;
            st_nxt = acs_pkg::ST_RACK;
          end
          else if (ev.scl_fall)
          begin
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = ~sh_r[6]; // [RULE16]
          end
        end
        acs_pkg::ST_RACK:
        begin
          if (ev.scl_rise && ev.sda)
            st_nxt = acs_pkg::ST_IDLE; // [RULE17]
          else if (ev.scl_rise)
          begin
            // Master acked: next byte, the top one repeats
            sub_nxt = sub_inc; // [RULE12] [RULE17]
            ack_nxt = 1'b1;
            st_nxt = acs_pkg::ST_RDATA;
          end
        end
        default:
        begin
          // Idle only ever releases the line
          oe_nxt = 1'b0; // [RULE1] [RULE7]
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= acs_pkg::ST_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      sub_r <= '0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      ovf_r <= 1'b0;
      sda_val_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      sub_r <= sub_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
      ovf_r <= ovf_nxt;
      sda_val_r <= 1'b0;
    end
  end

  // One byte register per subaddress; soft reset reloads every one,
  // including the reset bit itself, so it clears on its own
  generate
    for (g = 0; g < acs_pkg::NUM_REGS; g++)
    begin : g_reg
      logic [7:0] q_r;
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          q_r <= acs_pkg::REG_DEFAULTS[g];
        else if (clk_en && srst)
          q_r <= acs_pkg::REG_DEFAULTS[g]; // [RULE18]
        else if (clk_en && wr_en && sub_r == 3'(g))
          q_r <= sh_r;
      end
      assign regs[g] = q_r;
    end
  endgenerate

  // Open drain: the value is always low, only the enable moves
  assign sda_val = sda_val_r;
  assign sda_en = oe_r;
  assign cfg_regs = regs;

  stop_to_idle_a: assert property ( // [RULE8]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && ev.stop |=> st_r == acs_pkg::ST_IDLE && !sda_en)
    else $error("Stop did not return to idle");

  start_to_addr_a: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && ev.start |=> st_r == acs_pkg::ST_ADDR && cnt_r == 4'h0 && !sda_en)
    else $error("Start did not open an address byte");

  addr_ack_a: assert property ( // [RULE6]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_ADDR && byte_done
      && sh_r[7:1] == acs_pkg::DEV_ADDR
    |=> sda_en && ack_r && st_r == (sh_r[0] ? acs_pkg::ST_RDATA : acs_pkg::ST_SUB))
    else $error("Matching address not acknowledged");

  addr_miss_a: assert property ( // [RULE7]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_ADDR && byte_done
      && sh_r[7:1] != acs_pkg::DEV_ADDR
    |=> st_r == acs_pkg::ST_IDLE && !sda_en)
    else $error("Foreign address not released");

  bad_sub_a: assert property ( // [RULE11]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_SUB && byte_done
      && sh_r >= acs_pkg::SUB_LIMIT
    |=> st_r == acs_pkg::ST_IDLE && !sda_en)
    else $error("Invalid subaddress acknowledged");

  over_write_a: assert property ( // [RULE14]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_WDATA && byte_done && ovf_r
    |=> st_r == acs_pkg::ST_IDLE && !sda_en && $stable(cfg_regs))
    else $error("Byte past top register not dropped");

  write_step_a: assert property ( // [RULE12]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && wr_en && sub_r != acs_pkg::TOP_SUB
    |=> sub_r == $past(sub_r) + acs_pkg::SUB_STEP && sda_en)
    else $error("Subaddress did not advance on write");

  read_hold_a: assert property ( // [RULE17]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_RACK && ev.scl_rise
      && !ev.sda && sub_r == acs_pkg::TOP_SUB
    |=> sub_r == acs_pkg::TOP_SUB && st_r == acs_pkg::ST_RDATA)
    else $error("Read past top did not repeat top register");

  read_nack_a: assert property ( // [RULE17]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_RACK && ev.scl_rise && ev.sda
    |=> st_r == acs_pkg::ST_IDLE && !sda_en)
    else $error("Master nack did not end the read");

  soft_reset_a: assert property ( // [RULE18]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && srst |=> cfg_regs == acs_pkg::REG_DEFAULTS)
    else $error("Soft reset did not restore defaults");

  sub_ack_a: assert property ( // [RULE13]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_SUB && byte_done
      && sh_r < acs_pkg::SUB_LIMIT
    |=> sda_en && ack_r && st_r == acs_pkg::ST_WDATA && sub_r == $past(sh_r[2:0]))
    else $error("Valid subaddress not acknowledged");

  ack_release_a: assert property ( // [RULE6] [RULE13]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && ack_r && ev.scl_fall && st_r != acs_pkg::ST_RDATA
    |=> !sda_en && !ack_r)
    else $error("Acknowledge held past ninth clock");

  read_bit_hold_a: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    clk_en && !ev.stop && !ev.start && st_r == acs_pkg::ST_RDATA && !ev.scl_fall
    |=> $stable(sda_en))
    else $error("Read bit moved outside SCL low");

  idle_quiet_a: assert property ( // [RULE1]
    @(posedge ref_clk) disable iff (!rst_b)
    st_r == acs_pkg::ST_IDLE |-> !sda_en && !sda_val)
    else $error("Line driven while idle");

endmodule

// ### acs_pkg.sv
package acs_pkg;
  // Bus address, byte framing, subaddress range, soft reset bit and register count
  localparam logic [6:0] DEV_ADDR = 7'h70;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] SUB_LIMIT = 8'h08;
  localparam logic [2:0] TOP_SUB = 3'h7;
  localparam logic [2:0] SUB_STEP = 3'h1;
  localparam int SRST_BIT = 7;
  localparam int NUM_REGS = 8;

  // Register subaddresses
  localparam logic [2:0] OFS_POWER_RESET_CLOCK_SELECT = 3'h0;
  localparam logic [2:0] OFS_SYSTEM_FILTER_LOWPOWER_CONFIG = 3'h1;
  localparam logic [2:0] OFS_AUDIO_PORT_FORMAT_A = 3'h2;
  localparam logic [2:0] OFS_AUDIO_PORT_FORMAT_B = 3'h3;
  localparam logic [2:0] OFS_SLOT_CHOICE = 3'h4;
  localparam logic [2:0] OFS_VOLUME_LEVEL = 3'h5;
  localparam logic [2:0] OFS_GAIN_AND_MUTE = 3'h6;
  localparam logic [2:0] OFS_FAULT_FLAGS_RECOVERY = 3'h7;

  // Register reset values
  localparam logic [7:0] RST_POWER_RESET_CLOCK_SELECT = 8'h05;
  localparam logic [7:0] RST_SYSTEM_FILTER_LOWPOWER_CONFIG = 8'h30;
  localparam logic [7:0] RST_AUDIO_PORT_FORMAT_A = 8'h02;
  localparam logic [7:0] RST_AUDIO_PORT_FORMAT_B = 8'h00;
  localparam logic [7:0] RST_SLOT_CHOICE = 8'h00;
  localparam logic [7:0] RST_VOLUME_LEVEL = 8'h40;
  localparam logic [7:0] RST_GAIN_AND_MUTE = 8'h11;
  localparam logic [7:0] RST_FAULT_FLAGS_RECOVERY = 8'h0c;

  // Index i of this array is the register at subaddress i
  localparam logic [7:0][7:0] REG_DEFAULTS = {
    RST_FAULT_FLAGS_RECOVERY, RST_GAIN_AND_MUTE, RST_VOLUME_LEVEL,
    RST_SLOT_CHOICE, RST_AUDIO_PORT_FORMAT_B, RST_AUDIO_PORT_FORMAT_A,
    RST_SYSTEM_FILTER_LOWPOWER_CONFIG, RST_POWER_RESET_CLOCK_SELECT};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SUB,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } acs_state_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } acs_line_ev_type;
endpackage

// ### acs_i2c_master_model.sv
`timescale 1ns/10ps
module acs_i2c_master_model (
  // Clock
  input wire logic ref_clk,
  // Two-wire bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic r;

  // Both lines released while no frame is on the bus
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter SCL period; the target needs about six clocks per half period
  task automatic qtr();
    repeat (4) @(negedge ref_clk);
  endtask

  // Also used as repeated start, one condition per SCL high
  task automatic start_cond();
    // Let the target drop its acknowledge before SCL rises again
    qtr();
    sda_low = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_low = 1'b0;
    qtr();
  endtask

  // Data moves only while SCL is low
  task automatic bit_io(input logic b, output logic v);
    qtr();
    sda_low = !b;
    qtr();
    scl = 1'b1;
    qtr();
    v = sda;
    qtr();
    scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!more, r);
  endtask
endmodule

// ### tb.sv
`timescale 1ns/10ps
module tb;
  logic ref_clk;
  logic rst_b;
  logic scl;
  logic sda_low;
  logic sda_val;
  logic sda_en;
  logic clk_en;
  logic [63:0] cfg_regs;
  logic [7:0] mdl [8];
  logic [7:0] d;
  logic ack;
  int fail_count = 0;
  int total_checks = 0;
  // Pull-up wire: low when any party pulls it
  wire logic sda = !sda_low && !(sda_en && !sda_val);

  acs_i2c_slave u_acs_i2c_slave (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .scl_pin(scl), .sda_pin(sda), .sda_val(sda_val), .sda_en(sda_en), .cfg_regs(cfg_regs));
  acs_i2c_master_model u_acs_i2c_master_model (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));

  always #10 ref_clk = !ref_clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic mdl_rst();
    for (int i = 0; i < 8; i++)
      mdl[i] = acs_pkg::REG_DEFAULTS[i];
  endtask

  task automatic chk_regs();
    chk("sda_en", 8'h00, {7'h0, sda_en});
    for (int i = 0; i < 8; i++)
      chk("cfg_regs", mdl[i], cfg_regs[8*i +: 8]);
  endtask

  task automatic addr(input logic rd);
    u_acs_i2c_master_model.start_cond();
    u_acs_i2c_master_model.send_byte({acs_pkg::DEV_ADDR, rd}, ack);
    chk("addr_ack", 8'h01, {7'h0, ack});
  endtask

  task automatic wr(input logic [7:0] sub, input int n, input logic [7:0] first);
    int p;
    logic [7:0] v;
    p = (sub < 8) ? int'(sub) : 9;
    v = first;
    addr(1'b0);
    u_acs_i2c_master_model.send_byte(sub, ack);
    chk("sub_ack", {7'h0, sub < 8}, {7'h0, ack});
    for (int k = 0; k < n && p <= 8; k++)
    begin
      u_acs_i2c_master_model.send_byte(v, ack);
      chk("data_ack", {7'h0, p < 8}, {7'h0, ack});
      if (p < 8)
        mdl[p] = v;
      if (p == 0 && v[acs_pkg::SRST_BIT])
        mdl_rst();
      p++;
      v = 8'($urandom);
    end
    u_acs_i2c_master_model.stop_cond();
    chk_regs();
  endtask

  task automatic rd(input logic [7:0] sub, input int n);
    int p;
    p = int'(sub);
    addr(1'b0);
    u_acs_i2c_master_model.send_byte(sub, ack);
    chk("rd_sub_ack", 8'h01, {7'h0, ack});
    addr(1'b1);
    for (int k = 0; k < n; k++)
    begin
      u_acs_i2c_master_model.recv_byte(k < n - 1, d);
      chk("read_data", mdl[p], d);
      if (p < 7)
        p++;
    end
    u_acs_i2c_master_model.stop_cond();
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    void'($urandom(525));
    mdl_rst();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk_regs();
    for (int k = 0; k < 4; k++)
    begin
      d = 8'($urandom);
      if (d[7:1] == acs_pkg::DEV_ADDR)
        d[2] = !d[2];
      u_acs_i2c_master_model.start_cond();
      u_acs_i2c_master_model.send_byte(d, ack);
      chk("bad_addr_ack", 8'h00, {7'h0, ack});
      u_acs_i2c_master_model.send_byte(8'h00, ack);
      chk("idle_ack", 8'h00, {7'h0, ack});
      u_acs_i2c_master_model.stop_cond();
    end
    wr(8'h02, 7, 8'($urandom));
    wr(8'($urandom) | 8'h08, 1, 8'h00);
    rd(8'h00, 8);
    rd(8'h05, 5);
    // Stop in mid-byte, then a start in mid-byte before a good write
    addr(1'b0);
    u_acs_i2c_master_model.send_byte(8'h03, ack);
    repeat (4) u_acs_i2c_master_model.bit_io(1'b0, ack);
    u_acs_i2c_master_model.stop_cond();
    chk_regs();
    addr(1'b0);
    repeat (3) u_acs_i2c_master_model.bit_io(1'b1, ack);
    wr(8'h03, 2, 8'($urandom));
    wr(8'h00, 2, 8'h80);
    repeat (4) wr(8'($urandom % 8), 1 + $urandom % 3, 8'($urandom));
    rd(8'h00, 9);
    // A frozen block misses a whole frame and stays idle after it
    repeat (8) @(negedge ref_clk);
    clk_en = 1'b0;
    u_acs_i2c_master_model.start_cond();
    u_acs_i2c_master_model.send_byte({acs_pkg::DEV_ADDR, 1'b0}, ack);
    chk("frozen_ack", 8'h00, {7'h0, ack});
    u_acs_i2c_master_model.stop_cond();
    repeat (8) @(negedge ref_clk);
    clk_en = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk_regs();
    // Reset in mid-run brings back every default
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    mdl_rst();
    repeat (8) @(negedge ref_clk);
    chk_regs();
    rd(8'h06, 3);
    finish_test();
  end

  initial
  begin
    #1000000;
    fail_count++;
    finish_test();
  end
endmodule
